// ==== rtl/cpl_pkg.sv ====
// Package of constants and types for the calibration pot loader
package cpl_pkg;
  // Host port offsets, relative to the board base address
  localparam logic [2:0] OFS_SETUP = 3'h0;
  localparam logic [2:0] OFS_COMMAND = 3'h1;
  localparam logic [2:0] OFS_PTR_LO = 3'h2;
  localparam logic [2:0] OFS_PTR_HI = 3'h3;
  localparam logic [2:0] OFS_WRITE_PORT = 3'h4;
  localparam logic [2:0] OFS_READ_PORT = 3'h6;
  // Command register fields
  localparam int CMD_CH_LSB = 0;
  localparam int CMD_RANGE_LSB = 5;
  // Setup register fields
  localparam int SETUP_SE_BIT = 0;
  localparam int SETUP_CAL_BIT = 1;
  localparam int SETUP_REF_BIT = 2;
  localparam int SETUP_BUSY_BIT = 7;
  // Setup codes used by calibration software
  localparam logic [7:0] SETUP_DIFF = 8'h10;
  localparam logic [7:0] SETUP_SE = 8'h11;
  localparam logic [7:0] SETUP_CAL_GND = 8'h13;
  localparam logic [7:0] SETUP_CAL_REF = 8'h17;
  // Reset values
  localparam logic [6:0] SETUP_RESET = 7'h11;
  localparam logic [7:0] CMD_RESET = 8'h00;
  localparam logic [7:0] POT_MID = 8'h80;
  localparam logic [10:0] PTR_RESET = 11'h000;
  // Calibration memory layout
  localparam int MEM_DEPTH = 2048;
  localparam logic [1:0] BLK_USER_OFS = 2'h0;
  localparam logic [1:0] BLK_USER_GAIN = 2'h1;
  localparam logic [1:0] BLK_FACT_OFS = 2'h2;
  localparam logic [1:0] BLK_FACT_GAIN = 2'h3;
  localparam logic [4:0] DIFF_CH_MASK = 5'h0F;
  // Timing: a byte store takes about one millisecond
  localparam int CLK_NS = 40;
  localparam int STORE_NS = 1000000;
  localparam int STORE_CYCLES = (STORE_NS + CLK_NS - 1) / CLK_NS;
  localparam int STORE_CNT_W = 16;

  // Command byte as range plus channel
  typedef struct packed {
    logic [2:0] range;
    logic [4:0] channel;
  } cpl_cmd_t;

  // Pending byte store
  typedef struct packed {
    logic [10:0] addr;
    logic [7:0] data;
  } cpl_store_t;
endpackage : cpl_pkg

// ==== rtl/cpl_loader.sv ====
// Calibration memory, host ports and digital pot loader
// Function
// RULE1: Command byte holds channel in bits 4..0 and range in bits 7..5.
// RULE2: Range codes 000..101 select gains 0.5, 1, 2, 50, 100, 200.
// RULE3: Each command write fetches calibration bytes and loads both pots.
// RULE4: Busy flag, setup bit 7, stays high during a one millisecond store.
// RULE5: Eleven-bit byte pointer, low byte at offset 2, high at 3.
// RULE6: Byte written at offset 4 is stored at the current pointer.
// RULE7: Read at offset 6 returns byte at pointer, no busy wait.
// RULE8: Host waits for busy low before next pointer and store.
// RULE9: Setup 10h selects differential inputs, 11h single-ended inputs.
// RULE10: Setup 13h grounds amplifier input and enables calibration loading.
// RULE11: Setup 17h enables calibration, routes reference, selects single-ended.
// RULE12: Memory holds 24 blocks: four kinds times six gains.
// RULE13: User offset at range*20h plus channel; user gain 100h higher.
// RULE14: Byte 80h is the pot midpoint, near zero correction.
// RULE15: Host fills first 1C0h bytes with midpoint before calibrating.
// RULE16: Channels 0..31 single-ended, 0..15 differential; host stays in limit.
// RULE17: Factory offset sits 200h, factory gain 300h above user offset.
// RULE18: Pots hold their values until the next command write.
`timescale 1ns/1ns
`default_nettype none
module cpl_loader #(
  parameter int STORE_CYCLES = cpl_pkg::STORE_CYCLES
) (
  // Clock and reset
  input wire logic sys_clk_i,
  input wire logic rst_i,
  // Host I/O port
  input wire logic [2:0] io_addr_i,
  input wire logic io_wr_i,
  input wire logic io_rd_i,
  input wire logic [7:0] io_wdata_i,
  output logic [7:0] io_rdata_o,
  // Signal path control
  output logic [4:0] channel_o,
  output logic [2:0] gain_sel_o,
  output logic single_ended_mode_o,
  output logic cal_enable_o,
  output logic ref_select_o,
  // Digital pots
  output logic [7:0] offset_pot_o,
  output logic [7:0] gain_pot_o,
  output logic pot_load_o
);

  // Fetch states, Gray coded
  typedef enum logic [1:0] {
    CPL_IDLE = 2'b00,
    CPL_FETCH = 2'b01
  } cpl_state_t;

  // Byte address of a calibration entry from block, range and channel
  // RULE12: four blocks per range
  // RULE17: factory blocks above user
  function automatic logic [10:0] cpl_cal_addr(input logic [1:0] blk,
                                               input logic [2:0] range,
                                               input logic [4:0] ch);
    cpl_cal_addr = {1'b0, blk, range, ch};
  endfunction : cpl_cal_addr

  // Calibration memory, one byte per location
  logic [7:0] mem [cpl_pkg::MEM_DEPTH];

  logic [6:0] setup;
  logic [6:0] next_setup;
  cpl_pkg::cpl_cmd_t cmd;
  cpl_pkg::cpl_cmd_t next_cmd;
  logic [10:0] ptr;
  logic [10:0] next_ptr;
  logic [7:0] rdata;
  logic [7:0] next_rdata;
  cpl_pkg::cpl_store_t store;
  cpl_pkg::cpl_store_t next_store;
  logic [cpl_pkg::STORE_CNT_W-1:0] store_cnt;
  logic [cpl_pkg::STORE_CNT_W-1:0] next_store_cnt;
  logic busy;
  logic commit;
  cpl_state_t state;
  cpl_state_t next_state;
  logic [7:0] ofs_pot;
  logic [7:0] next_ofs_pot;
  logic [7:0] gain_pot;
  logic [7:0] next_gain_pot;
  logic pot_load;
  logic next_pot_load;
  logic [4:0] eff_ch;

  assign busy = store_cnt != '0;

  // Host register writes and read data
  always_comb begin
    next_setup = setup;
    next_cmd = cmd;
    next_ptr = ptr;
    next_rdata = rdata;
    if (io_wr_i) begin
      unique case (io_addr_i)
        // RULE9: mode from setup
        cpl_pkg::OFS_SETUP: next_setup = io_wdata_i[6:0];
        // RULE1: channel and range together
        cpl_pkg::OFS_COMMAND: next_cmd = io_wdata_i;
        // RULE5: pointer low and high bytes
        cpl_pkg::OFS_PTR_LO: next_ptr = {ptr[10:8], io_wdata_i};
        cpl_pkg::OFS_PTR_HI: next_ptr = {io_wdata_i[2:0], ptr[7:0]};
        default: next_ptr = ptr;
      endcase
    end
    if (io_rd_i) begin
      unique case (io_addr_i)
        // RULE4: busy shown in bit 7
        cpl_pkg::OFS_SETUP: next_rdata = {busy, setup};
        // RULE7: direct read at pointer
        cpl_pkg::OFS_READ_PORT: next_rdata = mem[ptr];
        // Write-only and unmapped offsets read as zero
        default: next_rdata = 8'h00;
      endcase
    end
  end

  // Host register state
  always_ff @(posedge sys_clk_i) begin
    if (rst_i) begin
      setup <= cpl_pkg::SETUP_RESET;
      cmd <= cpl_pkg::CMD_RESET;
      ptr <= cpl_pkg::PTR_RESET;
      rdata <= 8'h00;
    end else begin
      setup <= next_setup;
      cmd <= next_cmd;
      ptr <= next_ptr;
      rdata <= next_rdata;
    end
  end

  // Byte store timing; a write while busy is dropped, the host must poll
  always_comb begin
    next_store = store;
    next_store_cnt = store_cnt;
    commit = 1'b0;
    if (busy) begin
      next_store_cnt = store_cnt - 1'b1;
      commit = store_cnt == 16'h0001;
    end
    // RULE6: capture byte and pointer
    if (io_wr_i && io_addr_i == cpl_pkg::OFS_WRITE_PORT && !busy) begin
      next_store = '{addr: ptr, data: io_wdata_i};
      // RULE4: busy for the store time
      next_store_cnt = STORE_CYCLES[cpl_pkg::STORE_CNT_W-1:0];
    end
  end

  // Store registers
  always_ff @(posedge sys_clk_i) begin
    if (rst_i) begin
      store <= '0;
      store_cnt <= '0;
    end else begin
      store <= next_store;
      store_cnt <= next_store_cnt;
    end
  end

  // Byte lands at the end of the store, so reads during it show the old value
  always_ff @(posedge sys_clk_i) begin
    if (commit) begin
      mem[store.addr] <= store.data;
    end
  end

  // RULE16: differential mode wraps to 16 channels
  assign eff_ch = setup[cpl_pkg::SETUP_SE_BIT] ? cmd.channel
                                                : (cmd.channel & cpl_pkg::DIFF_CH_MASK);

  // Pot fetch sequence
  always_comb begin
    next_state = state;
    next_ofs_pot = ofs_pot;
    next_gain_pot = gain_pot;
    next_pot_load = 1'b0;
    unique case (state)
      CPL_IDLE: begin
        // RULE3: every command write starts a fetch
        if (io_wr_i && io_addr_i == cpl_pkg::OFS_COMMAND) begin
          next_state = CPL_FETCH;
        end
      end
      CPL_FETCH: begin
        // RULE13: user offset and gain locations
        next_ofs_pot = mem[cpl_cal_addr(cpl_pkg::BLK_USER_OFS, cmd.range, eff_ch)];
        next_gain_pot = mem[cpl_cal_addr(cpl_pkg::BLK_USER_GAIN, cmd.range, eff_ch)];
        next_pot_load = 1'b1;
        // Back-to-back command writes refetch with the newest code
        if (!(io_wr_i && io_addr_i == cpl_pkg::OFS_COMMAND)) begin
          next_state = CPL_IDLE;
        end
      end
      default: next_state = CPL_IDLE;
    endcase
  end

  // RULE18: pots change only on a fetch; RULE14: midpoint at reset
  always_ff @(posedge sys_clk_i) begin
    if (rst_i) begin
      state <= CPL_IDLE;
      ofs_pot <= cpl_pkg::POT_MID;
      gain_pot <= cpl_pkg::POT_MID;
      pot_load <= 1'b0;
    end else begin
      state <= next_state;
      ofs_pot <= next_ofs_pot;
      gain_pot <= next_gain_pot;
      pot_load <= next_pot_load;
    end
  end

  // Outputs straight from flip-flops
  assign io_rdata_o = rdata;
  // RULE2: range code drives the gain selector
  assign gain_sel_o = cmd.range;
  assign channel_o = cmd.channel;
  // RULE10: calibration and ground switch
  assign cal_enable_o = setup[cpl_pkg::SETUP_CAL_BIT];
  // RULE11: reference routing and input mode
  assign ref_select_o = setup[cpl_pkg::SETUP_REF_BIT];
  assign single_ended_mode_o = setup[cpl_pkg::SETUP_SE_BIT];
  assign offset_pot_o = ofs_pot;
  assign gain_pot_o = gain_pot;
  assign pot_load_o = pot_load;

  // Assertion helpers
  logic cmd_wr;
  logic port_wr;
  assign cmd_wr = io_wr_i && io_addr_i == cpl_pkg::OFS_COMMAND;
  assign port_wr = io_wr_i && io_addr_i == cpl_pkg::OFS_WRITE_PORT;

  sequence cmd_write_s;
    cmd_wr ##1 (state == CPL_FETCH);
  endsequence

  sequence store_start_s;
    port_wr && !busy ##1 busy;
  endsequence

  cmd_fields_a: assert property (@(posedge sys_clk_i) disable iff (rst_i) // RULE1
    cmd_wr |=> channel_o == $past(io_wdata_i[4:0]) && gain_sel_o == $past(io_wdata_i[7:5]))
    else $error("command fields not taken from written byte");

  pot_fetch_a: assert property (@(posedge sys_clk_i) disable iff (rst_i) // RULE3
    cmd_write_s |=> pot_load_o && offset_pot_o == $past(mem[cpl_cal_addr(
      cpl_pkg::BLK_USER_OFS, cmd.range, eff_ch)]))
    else $error("pots not loaded after command write");

  gain_fetch_a: assert property (@(posedge sys_clk_i) disable iff (rst_i) // RULE13
    state == CPL_FETCH |=> gain_pot_o == $past(mem[cpl_cal_addr(
      cpl_pkg::BLK_USER_GAIN, cmd.range, eff_ch)]))
    else $error("gain pot not loaded from user gain block");

  busy_start_a: assert property (@(posedge sys_clk_i) disable iff (rst_i) // RULE4
    port_wr && !busy |=> store_cnt == STORE_CYCLES[cpl_pkg::STORE_CNT_W-1:0])
    else $error("store does not start busy time");

  busy_hold_a: assert property (@(posedge sys_clk_i) disable iff (rst_i) // RULE4
    store_start_s |-> busy [*8])
    else $error("busy dropped early");

  busy_read_a: assert property (@(posedge sys_clk_i) disable iff (rst_i) // RULE4
    io_rd_i && io_addr_i == cpl_pkg::OFS_SETUP |=> io_rdata_o[7] == $past(busy))
    else $error("setup read does not show busy");

  ptr_bytes_a: assert property (@(posedge sys_clk_i) disable iff (rst_i) // RULE5
    io_wr_i && io_addr_i == cpl_pkg::OFS_PTR_HI |=>
      ptr == {$past(io_wdata_i[2:0]), $past(ptr[7:0])})
    else $error("pointer high byte not taken");

  store_addr_a: assert property (@(posedge sys_clk_i) disable iff (rst_i) // RULE6
    port_wr && !busy |=> store.addr == $past(ptr) && store.data == $past(io_wdata_i))
    else $error("store not captured at pointer");

  read_port_a: assert property (@(posedge sys_clk_i) disable iff (rst_i) // RULE7
    io_rd_i && io_addr_i == cpl_pkg::OFS_READ_PORT |=> io_rdata_o == $past(mem[ptr]))
    else $error("read port wrong byte");

  pot_hold_a: assert property (@(posedge sys_clk_i) disable iff (rst_i) // RULE18
    state == CPL_IDLE |=> $stable(offset_pot_o) && $stable(gain_pot_o))
    else $error("pots changed without a command write");

  diff_wrap_a: assert property (@(posedge sys_clk_i) disable iff (rst_i) // RULE16
    state == CPL_FETCH && !single_ended_mode_o |=>
      offset_pot_o == $past(mem[{3'h0, cmd.range, 1'b0, cmd.channel[3:0]}]))
    else $error("differential channel beyond 15");

  store_land_a: assert property (@(posedge sys_clk_i) disable iff (rst_i) // RULE6
    commit |=> mem[$past(store.addr)] == $past(store.data))
    else $error("stored byte did not land at its pointer");

  busy_end_a: assert property (@(posedge sys_clk_i) disable iff (rst_i) // RULE4
    commit |=> !busy)
    else $error("busy not cleared after the store");

  load_pulse_a: assert property (@(posedge sys_clk_i) disable iff (rst_i) // RULE3
    cmd_wr |-> ##2 pot_load_o)
    else $error("no load pulse two cycles after a command write");

endmodule : cpl_loader
`default_nettype wire

// ==== verif/cpl_host_model.sv ====
// Host processor model for the calibration loader port
`timescale 1ns/1ns
`default_nettype none
module cpl_host_model (
  // Clock
  input wire logic sys_clk_i,
  // Device port
  output logic [2:0] io_addr_o,
  output logic io_wr_o,
  output logic io_rd_o,
  output logic [7:0] io_wdata_o,
  input wire logic [7:0] io_rdata_i
);
  // Polls that ran out without seeing busy low
  int timeouts = 0;
  // Bus idle at time zero
  initial begin
    io_addr_o = 3'h0;
    io_wr_o = 1'b0;
    io_rd_o = 1'b0;
    io_wdata_o = 8'h00;
  end
  // One write strobe; data inverted after so a stale value is never seen
  task automatic wr(input logic [2:0] a, input logic [7:0] d);
    @(posedge sys_clk_i);
    io_addr_o <= a;
    io_wdata_o <= d;
    io_wr_o <= 1'b1;
    @(posedge sys_clk_i);
    io_wr_o <= 1'b0;
    io_wdata_o <= ~d;
  endtask : wr
  // One read strobe, data taken the cycle after
  task automatic rd(input logic [2:0] a, output logic [7:0] d);
    @(posedge sys_clk_i);
    io_addr_o <= a;
    io_rd_o <= 1'b1;
    @(posedge sys_clk_i);
    io_rd_o <= 1'b0;
    @(posedge sys_clk_i);
    #1;
    d = io_rdata_i;
  endtask : rd
  // Pointer written low byte then high byte
  task automatic setptr(input logic [10:0] p);
    wr(cpl_pkg::OFS_PTR_LO, p[7:0]);
    wr(cpl_pkg::OFS_PTR_HI, {5'h00, p[10:8]});
  endtask : setptr
  task automatic wait_idle();
    logic [7:0] s;
    int n;
    s = 8'h80;
    n = 0;
    while (s[7] !== 1'b0 && n < 100) begin
      rd(cpl_pkg::OFS_SETUP, s);
      n++;
    end
    if (s[7] !== 1'b0) begin
      timeouts++;
    end
  endtask : wait_idle
  task automatic store(input logic [10:0] p, input logic [7:0] d);
    setptr(p);
    wr(cpl_pkg::OFS_WRITE_PORT, d);
    wait_idle();
  endtask : store
endmodule : cpl_host_model
`default_nettype wire

// ==== verif/cpl_loader_tb_top.sv ====
// Self-checking bench for the calibration pot loader
`timescale 1ns/1ns
`default_nettype none
module cpl_loader_tb_top;
  logic sys_clk_i = 1'b0;
  logic rst_i = 1'b1;
  logic [2:0] io_addr;
  logic io_wr;
  logic io_rd;
  logic [7:0] io_wdata;
  logic [7:0] io_rdata;
  logic [4:0] ch;
  logic [2:0] gsel;
  logic se;
  logic cal;
  logic refsel;
  logic [7:0] opot;
  logic [7:0] gpot;
  logic pload;
  int miscompares = 0;
  int samples_checked = 0;
  int cycles = 0;
  // Clock
  always #20 sys_clk_i = ~sys_clk_i;
  // Short store time keeps the run small
  cpl_loader #(.STORE_CYCLES(20)) DUT (.sys_clk_i(sys_clk_i), .rst_i(rst_i),
    .io_addr_i(io_addr), .io_wr_i(io_wr), .io_rd_i(io_rd), .io_wdata_i(io_wdata),
    .io_rdata_o(io_rdata), .channel_o(ch), .gain_sel_o(gsel),
    .single_ended_mode_o(se), .cal_enable_o(cal), .ref_select_o(refsel),
    .offset_pot_o(opot), .gain_pot_o(gpot), .pot_load_o(pload));
  cpl_host_model host (.sys_clk_i(sys_clk_i), .io_addr_o(io_addr), .io_wr_o(io_wr),
    .io_rd_o(io_rd), .io_wdata_o(io_wdata), .io_rdata_i(io_rdata));
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    samples_checked++;
    if (got !== exp) begin
      miscompares++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk
  task automatic tally_and_finish();
    miscompares += host.timeouts;
    $display("checks=%0d mismatches=%0d", samples_checked, miscompares);
    if (miscompares == 0 && samples_checked > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask : tally_and_finish
  // Cut a hang short well past the expected run length
  always @(posedge sys_clk_i) begin
    cycles++;
    if (cycles == 40000) begin
      miscompares++;
      tally_and_finish();
    end
  end
  // Command write, then the load pulse must come within a few cycles
  task automatic cmd(input logic [7:0] c);
    logic seen;
    seen = 1'b0;
    host.wr(cpl_pkg::OFS_COMMAND, c);
    repeat (4) begin
      @(posedge sys_clk_i);
      #1;
      seen = seen | (pload === 1'b1);
    end
    chk({7'h00, seen}, 8'h01);
  endtask : cmd
  task automatic t_reset();
    logic [7:0] v;
    host.rd(cpl_pkg::OFS_SETUP, v);
    chk(v, 8'h11);
    chk(opot, 8'h80);
    chk(gpot, 8'h80);
    host.rd(cpl_pkg::OFS_COMMAND, v);
    chk(v, 8'h00);
    host.rd(3'h7, v);
    chk(v, 8'h00);
    $display("test reset done");
  endtask : t_reset
  // Midpoint fill of the user area, then a load must give centred pots
  task automatic t_fill();
    logic [7:0] v;
    for (int a = 0; a < 448; a++) begin
      host.store(11'(a), 8'h80);
    end
    cmd(8'h00);
    chk(opot, 8'h80);
    chk(gpot, 8'h80);
    host.store(11'h225, 8'h3C);
    host.rd(cpl_pkg::OFS_READ_PORT, v);
    chk(v, 8'h3C);
    cmd(8'h25);
    chk(opot, 8'h80);
    $display("test fill done");
  endtask : t_fill
  // Store at the top pointer; a write while busy must be dropped
  task automatic t_store();
    logic [7:0] v;
    host.setptr(11'h7FF);
    host.wr(cpl_pkg::OFS_WRITE_PORT, 8'hA5);
    host.rd(cpl_pkg::OFS_SETUP, v);
    chk(v & 8'h80, 8'h80);
    host.wr(cpl_pkg::OFS_WRITE_PORT, 8'h5A);
    host.wait_idle();
    host.rd(cpl_pkg::OFS_READ_PORT, v);
    chk(v, 8'hA5);
    host.rd(cpl_pkg::OFS_READ_PORT, v);
    chk(v, 8'hA5);
    $display("test store done");
  endtask : t_store
  // Range codes 000..101, user offset and gain blocks, distinct bytes
  task automatic t_ranges();
    logic [10:0] a;
    for (int r = 0; r < 6; r++) begin
      a = 11'(r * 32 + r * 5);
      host.store(a, 8'(8'h40 + r));
      host.store(11'h100 + a, 8'(8'hC0 + r));
      cmd({3'(r), 5'(r * 5)});
      chk(opot, 8'(8'h40 + r));
      chk(gpot, 8'(8'hC0 + r));
      chk({gsel, ch}, {3'(r), 5'(r * 5)});
    end
    $display("test ranges done");
  endtask : t_ranges
  // Memory change alone must not move the pots
  task automatic t_hold();
    host.store(11'h0B9, 8'h11);
    chk(opot, 8'h45);
    cmd(8'hB9);
    chk(opot, 8'h11);
    $display("test hold done");
  endtask : t_hold
  task automatic t_setup();
    logic [7:0] codes [4];
    logic [7:0] v;
    codes = '{8'h10, 8'h11, 8'h13, 8'h17};
    foreach (codes[i]) begin
      host.wr(cpl_pkg::OFS_SETUP, codes[i]);
      host.rd(cpl_pkg::OFS_SETUP, v);
      chk(v, codes[i]);
      chk({5'h00, refsel, cal, se}, {5'h00, codes[i][2:0]});
    end
    host.wr(cpl_pkg::OFS_SETUP, 8'h10);
    cmd(8'h25);
    chk(opot, 8'h41);
    $display("test setup done");
  endtask : t_setup
  // Main sequence
  initial begin
    repeat (4) @(posedge sys_clk_i);
    rst_i <= 1'b0;
    t_reset();
    t_fill();
    t_store();
    t_ranges();
    t_hold();
    t_setup();
    tally_and_finish();
  end
endmodule : cpl_loader_tb_top
`default_nettype wire
